// ===== include/depo_pkg.sv
`default_nettype none
package depo_pkg;
    // Register byte offsets
    localparam logic [7:0] DEPO_OFS_NUM    = 8'h00;
    localparam logic [7:0] DEPO_OFS_DEN    = 8'h04;
    localparam logic [7:0] DEPO_OFS_SEL    = 8'h08;
    localparam logic [7:0] DEPO_OFS_RES    = 8'h0C;
    localparam logic [7:0] DEPO_OFS_STAT   = 8'h10;
    // Select register fields
    localparam int DEPO_SEL_BINV = 0;
    localparam int DEPO_SEL_SRC  = 1;
    // Reset values
    localparam logic [15:0] DEPO_NUM_RST = 16'h0001;
    localparam logic [15:0] DEPO_DEN_RST = 16'h0001;
    localparam logic [15:0] DEPO_RES_RST = 16'h2710;
    // AXI responses
    localparam logic [1:0] DEPO_RESP_OK  = 2'b00;
    localparam logic [1:0] DEPO_RESP_ERR = 2'b10;
    // Output edge rate limit after four-times count
    localparam int DEPO_CLK_MHZ      = 250;
    localparam int DEPO_MAX_EDGE_KPPS = 4000;
    // Least spacing between output edges, rounded up
    localparam int DEPO_STEP_CYC = (DEPO_CLK_MHZ * 1000 + DEPO_MAX_EDGE_KPPS - 1) / DEPO_MAX_EDGE_KPPS;
    localparam int DEPO_DIV_STEPS = 32;
    // Ratio check engine states
    typedef enum logic [0:0] {
        DEPO_CHK_IDLE = 1'b0,
        DEPO_CHK_RUN  = 1'b1
    } depo_chk_t;
    // Software configuration
    typedef struct packed {
        logic [15:0] numerator;
        logic [15:0] denominator;
        logic [15:0] resolution;
        logic        b_invert;
        logic        src_scale;
    } depo_cfg_t;
    // One quadrature input group
    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } depo_quad_t;
endpackage
`default_nettype wire

// ===== rtl/depo_top.sv
// Notes on behaviour
// - Quadrature output from encoder or scale
// - Output count scaled by numerator over denominator, ratios above one held to one
// - Select B inversion and pulse source
// - Output edge rate capped at 4 Mpps
// - Multiple of four, encoder source: Z aligned with A
// - Otherwise Z narrow, as wide as the source Z pulse
// - Z also on single-ended output
`default_nettype none
module depo_top
    import depo_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_z,
    input  wire logic        scale_a,
    input  wire logic        scale_b,
    input  wire logic        scale_z,
    output logic             phase_a_out_pos,
    output logic             phase_a_out_neg,
    output logic             phase_b_out_pos,
    output logic             phase_b_out_neg,
    output logic             index_out_pos,
    output logic             index_out_neg,
    output logic             index_out_single_o,
    output logic             index_out_single_oe,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // Quadrature phase code to count position
    function automatic logic [1:0] depo_pos(input logic a, input logic b);
        depo_pos = {b, a ^ b};
    endfunction

    logic [1:0]  rst_sync_reg;   // Reset release chain
    logic        rst_n;          // Synchronised reset
    depo_quad_t  enc_s1_reg;     // Encoder first stage
    depo_quad_t  enc_s2_reg;     // Encoder second stage
    depo_quad_t  scl_s1_reg;     // Scale first stage
    depo_quad_t  scl_s2_reg;     // Scale second stage
    depo_quad_t  src;            // Selected source
    logic [1:0]  in_pos_reg;     // Last input position
    logic [1:0]  in_delta;       // Input position change
    logic        fwd_edge;       // Forward input edge
    logic        rev_edge;       // Reverse input edge
    logic        z_last_reg;     // Previous source Z
    depo_cfg_t   cfg_reg;        // Configuration
    logic signed [17:0] acc_reg;  // Ratio accumulator
    logic signed [17:0] acc_next; // Accumulator next value
    logic signed [7:0]  pend_reg; // Output steps owed
    logic        add_fwd;        // Ratio emits forward step
    logic        add_rev;        // Ratio emits reverse step
    logic [6:0]  pace_reg;       // Cycles since last output edge
    logic        step_fire;      // Output edge this cycle
    logic [1:0]  out_pos_reg;    // Output position
    logic        z_pend_reg;     // Index owed to aligned output
    logic        z_out_reg;      // Index output state
    logic        z_seen_reg;     // At least one index seen
    depo_chk_t   chk_reg;        // Ratio check state
    logic [31:0] dvd_reg;        // Dividend shift register
    logic [18:0] rem_reg;        // Partial remainder
    logic [18:0] rem_sh;         // Shifted remainder
    logic [5:0]  chk_cnt_reg;    // Division step count
    logic        aligned_reg;    // Product over denominator is multiple of four
    logic        chk_start;      // Numerator, denominator or resolution written
    logic        chk_go_reg;     // Check start, settings in place
    logic        aw_hold_reg;    // Write address held
    logic        w_hold_reg;     // Write data held
    logic [7:0]  aw_addr_reg;    // Held write address
    logic [31:0] w_data_reg;     // Held write data
    logic [3:0]  w_strb_reg;     // Held strobes
    logic        wr_go;          // Both halves present
    logic        wr_hit;         // Write address mapped

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // Pin synchronisers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enc_s1_reg <= '0;
            enc_s2_reg <= '0;
            scl_s1_reg <= '0;
            scl_s2_reg <= '0;
        end
        else
        begin
            enc_s1_reg <= '{a: enc_a, b: enc_b, z: enc_z};
            enc_s2_reg <= enc_s1_reg;
            scl_s1_reg <= '{a: scale_a, b: scale_b, z: scale_z};
            scl_s2_reg <= scl_s1_reg;
        end
    end

    // Source choice and edge decode
    assign src      = cfg_reg.src_scale ? scl_s2_reg : enc_s2_reg;
    assign in_delta = depo_pos(src.a, src.b) - in_pos_reg;
    assign fwd_edge = (in_delta == 2'd1);
    assign rev_edge = (in_delta == 2'd3);

    // Input position and Z history
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_pos_reg <= 2'd0;
            z_last_reg <= 1'b0;
        end
        else
        begin
            in_pos_reg <= depo_pos(src.a, src.b);
            z_last_reg <= src.z;
        end
    end

    // Ratio accumulator, at most one output step per input edge
    always_comb
    begin
        acc_next = acc_reg;
        add_fwd  = 1'b0;
        add_rev  = 1'b0;
        if (fwd_edge)
        begin
            acc_next = acc_reg + $signed({2'b00, cfg_reg.numerator});
            if (acc_next >= $signed({2'b00, cfg_reg.denominator}))
            begin
                acc_next = acc_next - $signed({2'b00, cfg_reg.denominator});
                add_fwd  = 1'b1;
                // Ratio above one: clip, so the sum cannot run away
                if (acc_next >= $signed({2'b00, cfg_reg.denominator}))
                    acc_next = $signed({2'b00, cfg_reg.denominator}) - 18'sd1;
            end
        end
        else if (rev_edge)
        begin
            acc_next = acc_reg - $signed({2'b00, cfg_reg.numerator});
            if (acc_next <= -$signed({2'b00, cfg_reg.denominator}))
            begin
                acc_next = acc_next + $signed({2'b00, cfg_reg.denominator});
                add_rev  = 1'b1;
                // Same clip going backwards
                if (acc_next <= -$signed({2'b00, cfg_reg.denominator}))
                    acc_next = 18'sd1 - $signed({2'b00, cfg_reg.denominator});
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_reg <= '0;
        else if (chk_start)
            acc_reg <= '0;
        else
            acc_reg <= acc_next;
    end

    // Output edge pacing
    assign step_fire = (pend_reg != 8'sd0) && (pace_reg >= 7'(DEPO_STEP_CYC));

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pace_reg <= 7'd0;
        else if (step_fire)
            pace_reg <= 7'd1;
        else if (pace_reg < 7'(DEPO_STEP_CYC))
            pace_reg <= pace_reg + 7'd1;
    end

    // Owed steps, saturating
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pend_reg <= 8'sd0;
        else
        begin
            case ({add_fwd, add_rev, step_fire})
                3'b100:  pend_reg <= (pend_reg == 8'sd127) ? pend_reg : pend_reg + 8'sd1;
                3'b010:  pend_reg <= (pend_reg == -8'sd128) ? pend_reg : pend_reg - 8'sd1;
                3'b001:  pend_reg <= (pend_reg > 8'sd0) ? pend_reg - 8'sd1 : pend_reg + 8'sd1;
                3'b101:  pend_reg <= (pend_reg > 8'sd0) ? pend_reg : pend_reg + 8'sd2;
                3'b011:  pend_reg <= (pend_reg > 8'sd0) ? pend_reg - 8'sd2 : pend_reg;
                default: pend_reg <= pend_reg;
            endcase
        end
    end

    // Output quadrature position, sign of debt sets direction
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            out_pos_reg <= 2'd0;
        else if (step_fire)
            out_pos_reg <= (pend_reg > 8'sd0) ? out_pos_reg + 2'd1 : out_pos_reg - 2'd1;
    end

    // Index generation
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            z_pend_reg <= 1'b0;
            z_out_reg  <= 1'b0;
            z_seen_reg <= 1'b0;
        end
        else
        begin
            if (src.z && !z_last_reg)
                z_seen_reg <= 1'b1;
            if (aligned_reg && !cfg_reg.src_scale)
            begin
                // Aligned: index spans the quarter where A rises
                if (step_fire)
                begin
                    z_out_reg <= z_pend_reg && (out_pos_reg + 2'd1 == 2'd1) && (pend_reg > 8'sd0);
                    if (z_pend_reg && (out_pos_reg + 2'd1 == 2'd1) && (pend_reg > 8'sd0))
                        z_pend_reg <= 1'b0;
                end
                // A new index wins over the clear in the same cycle
                if (src.z && !z_last_reg)
                    z_pend_reg <= 1'b1;
            end
            else
            begin
                // Narrow: index follows source Z directly
                z_pend_reg <= 1'b0;
                z_out_reg  <= src.z;
            end
        end
    end

    // Differential and single-ended drive
    assign phase_a_out_pos     = out_pos_reg[1] ^ out_pos_reg[0];
    assign phase_a_out_neg     = ~phase_a_out_pos;
    assign phase_b_out_pos     = out_pos_reg[1] ^ cfg_reg.b_invert;
    assign phase_b_out_neg     = ~phase_b_out_pos;
    assign index_out_pos       = z_out_reg;
    assign index_out_neg       = ~z_out_reg;
    assign index_out_single_o  = 1'b0;
    assign index_out_single_oe = z_out_reg;

    // Start one cycle after the write, once the new settings stand
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            chk_go_reg <= 1'b0;
        else
            chk_go_reg <= chk_start;
    end

    // Multiple-of-four check: resolution*num mod 4*den
    assign rem_sh = {rem_reg[17:0], dvd_reg[31]};

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chk_reg     <= DEPO_CHK_IDLE;
            dvd_reg     <= '0;
            rem_reg     <= '0;
            chk_cnt_reg <= 6'd0;
            aligned_reg <= 1'b0;
        end
        else
        begin
            case (chk_reg)
                DEPO_CHK_IDLE:
                begin
                    // Wait for a settings change
                    chk_reg <= DEPO_CHK_IDLE;
                end
                DEPO_CHK_RUN:
                begin
                    dvd_reg <= {dvd_reg[30:0], 1'b0};
                    if (rem_sh >= {1'b0, cfg_reg.denominator, 2'b00})
                        rem_reg <= rem_sh - {1'b0, cfg_reg.denominator, 2'b00};
                    else
                        rem_reg <= rem_sh;
                    chk_cnt_reg <= chk_cnt_reg + 6'd1;
                    if (chk_cnt_reg == 6'(DEPO_DIV_STEPS))
                    begin
                        chk_reg     <= DEPO_CHK_IDLE;
                        aligned_reg <= (rem_reg == '0) && (cfg_reg.denominator != '0);
                    end
                end
                default: chk_reg <= DEPO_CHK_IDLE;
            endcase
            // Fresh settings: start over, even in mid-run
            if (chk_go_reg)
            begin
                chk_reg     <= DEPO_CHK_RUN;
                dvd_reg     <= {16'h0000, cfg_reg.resolution} * {16'h0000, cfg_reg.numerator};
                rem_reg     <= '0;
                chk_cnt_reg <= 6'd0;
            end
        end
    end

    // AXI4-Lite write side
    assign wr_go         = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign wr_hit        = (aw_addr_reg <= DEPO_OFS_STAT) && (aw_addr_reg[1:0] == 2'b00);
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    assign chk_start     = wr_go && wr_hit && (aw_addr_reg != DEPO_OFS_SEL) && (aw_addr_reg != DEPO_OFS_STAT);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            aw_addr_reg  <= '0;
            w_data_reg   <= '0;
            w_strb_reg   <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= DEPO_RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_hit && aw_addr_reg != DEPO_OFS_STAT) ? DEPO_RESP_OK : DEPO_RESP_ERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration registers with byte strobes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_reg <= '{numerator: DEPO_NUM_RST, denominator: DEPO_DEN_RST,
                         resolution: DEPO_RES_RST, b_invert: 1'b0, src_scale: 1'b0};
        else if (wr_go && wr_hit)
        begin
            case (aw_addr_reg)
                DEPO_OFS_NUM:
                begin
                    if (w_strb_reg[0]) cfg_reg.numerator[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) cfg_reg.numerator[15:8] <= w_data_reg[15:8];
                end
                DEPO_OFS_DEN:
                begin
                    if (w_strb_reg[0]) cfg_reg.denominator[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) cfg_reg.denominator[15:8] <= w_data_reg[15:8];
                end
                DEPO_OFS_RES:
                begin
                    if (w_strb_reg[0]) cfg_reg.resolution[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) cfg_reg.resolution[15:8] <= w_data_reg[15:8];
                end
                DEPO_OFS_SEL:
                begin
                    if (w_strb_reg[0])
                    begin
                        cfg_reg.b_invert  <= w_data_reg[DEPO_SEL_BINV];
                        cfg_reg.src_scale <= w_data_reg[DEPO_SEL_SRC];
                    end
                end
                default: cfg_reg <= cfg_reg;
            endcase
        end
    end

    // AXI4-Lite read side
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= DEPO_RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= DEPO_RESP_OK;
            case (s_axi_araddr)
                DEPO_OFS_NUM:  s_axi_rdata <= {16'h0000, cfg_reg.numerator};
                DEPO_OFS_DEN:  s_axi_rdata <= {16'h0000, cfg_reg.denominator};
                DEPO_OFS_SEL:  s_axi_rdata <= {30'h0000_0000, cfg_reg.src_scale, cfg_reg.b_invert};
                DEPO_OFS_RES:  s_axi_rdata <= {16'h0000, cfg_reg.resolution};
                DEPO_OFS_STAT: s_axi_rdata <= {16'h0000, pend_reg, 5'h00, z_seen_reg,
                                              chk_reg == DEPO_CHK_RUN, aligned_reg};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= DEPO_RESP_ERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_edge_spacing:  assert property (step_fire |=> !step_fire [*8]) else $error("edges too close");
    a_quarter_gap:   assert property ($changed(out_pos_reg) |-> $past(step_fire)) else $error("phase moved");
    a_gray_step:     assert property (step_fire |=> $countones({phase_a_out_pos, phase_b_out_pos}
                                      ^ $past({phase_a_out_pos, phase_b_out_pos})) == 1) else $error("not gray");
    a_diff_pair:     assert property (phase_a_out_pos != phase_a_out_neg) else $error("A pair equal");
    a_single_index:  assert property (index_out_single_oe == index_out_pos) else $error("single Z differs");
    a_ratio_step:    assert property (add_fwd && !step_fire && pend_reg < 8'sd127
                                      |=> pend_reg == $past(pend_reg) + 8'sd1) else $error("step lost");
    a_z_aligned:     assert property (aligned_reg && !cfg_reg.src_scale && $rose(index_out_pos)
                                      |-> phase_a_out_pos && !out_pos_reg[1]) else $error("Z not on A");
    a_z_narrow:      assert property (!aligned_reg && !cfg_reg.src_scale && $stable(aligned_reg)
                                      |=> index_out_pos == $past(enc_s2_reg.z)) else $error("Z not narrow");
    a_src_ignore:    assert property (cfg_reg.src_scale && $stable(cfg_reg) && scl_s2_reg == $past(scl_s2_reg)
                                      && !chk_start |-> !fwd_edge && !rev_edge) else $error("wrong source");
    a_bvalid_hold:   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");

    c_fwd_step:      cover property (step_fire && pend_reg > 8'sd0);
    c_rev_step:      cover property (step_fire && pend_reg < 8'sd0);
    c_z_aligned:     cover property (aligned_reg && $rose(index_out_pos));
    c_axi_write:     cover property (wr_go && wr_hit);
endmodule
`default_nettype wire

// ===== sim/depo_host_model.sv
`default_nettype none
module depo_host_model
    import depo_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        clr,
    input  wire logic        a_p,
    input  wire logic        a_n,
    input  wire logic        b_p,
    input  wire logic        b_n,
    input  wire logic        z_p,
    input  wire logic        z_n,
    output logic [31:0]      pos_cnt,
    output logic [31:0]      gap_min,
    output logic [31:0]      z_rise,
    output logic [31:0]      z_with_a,
    output logic [31:0]      bad_cnt,
    output logic             z_locked
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0]  g_reg;      // Last phase code seen
    logic [1:0]  dlt;        // Phase code step
    logic [31:0] since_reg;  // Cycles since last phase change
    logic        z_prev;     // Index level last cycle
    logic        a_prev;     // A level last cycle
    assign dlt = {b_p, a_p ^ b_p} - g_reg;
    // Count steps, watch spacing and line pairs
    always_ff @(posedge ref_clk)
    begin
        if (clr)
        begin
            g_reg     <= {b_p, a_p ^ b_p};
            pos_cnt   <= '0;
            gap_min   <= 32'h0000_FFFF;
            since_reg <= 32'h0000_FFFF;
            bad_cnt   <= '0;
        end
        else
        begin
            since_reg <= since_reg + 32'h0000_0001;
            // Step direction from which phase leads
            if (dlt != 2'h0)
            begin
                g_reg     <= {b_p, a_p ^ b_p};
                since_reg <= 32'h0000_0001;
                if (since_reg < gap_min) gap_min <= since_reg;
                if (dlt == 2'h1) pos_cnt <= pos_cnt + 32'h0000_0001;
                else if (dlt == 2'h3) pos_cnt <= pos_cnt - 32'h0000_0001;
                else bad_cnt <= bad_cnt + 32'h0000_0001;
            end
            // Differential pairs must stay complementary
            if (a_n !== ~a_p || b_n !== ~b_p || z_n !== ~z_p) bad_cnt <= bad_cnt + 32'h0000_0001;
        end
    end
    // Index pulses, and whether they ride on A rising
    always_ff @(posedge ref_clk)
    begin
        z_prev <= z_p;
        a_prev <= a_p;
        if (clr)
        begin
            z_rise   <= '0;
            z_with_a <= '0;
            z_locked <= 1'b0;
        end
        else if (z_p && !z_prev)
        begin
            z_rise   <= z_rise + 32'h0000_0001;
            z_locked <= 1'b1;
            if (a_p && !a_prev) z_with_a <= z_with_a + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// ===== sim/depo_top_test.sv
`default_nettype none
module depo_top_test;
    import depo_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 1'b0, rst_b = 1'b0, clr = 1'b0, enc_z = 1'b0;
    logic [1:0]  qg [2] = '{2'h0, 2'h0};  // Phase codes: encoder, scale
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d, pos_cnt, gap_min, z_rise, z_with_a, bad_cnt, za0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, ap, an, bp, bn, zp, zn, zs_o, zs_oe, z_locked;
    logic [1:0]  bresp, rresp, r;
    int          num_errors = 0, tests_run = 0;
    always #2 ref_clk = ~ref_clk;
    depo_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .enc_a(qg[0][0] ^ qg[0][1]), .enc_b(qg[0][1]),
        .enc_z(enc_z), .scale_a(qg[1][0] ^ qg[1][1]), .scale_b(qg[1][1]), .scale_z(1'b0),
        .phase_a_out_pos(ap), .phase_a_out_neg(an), .phase_b_out_pos(bp), .phase_b_out_neg(bn),
        .index_out_pos(zp), .index_out_neg(zn), .index_out_single_o(zs_o), .index_out_single_oe(zs_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    depo_host_model i_host (.ref_clk(ref_clk), .clr(clr), .a_p(ap), .a_n(an), .b_p(bp), .b_n(bn),
        .z_p(zp), .z_n(zn), .pos_cnt(pos_cnt), .gap_min(gap_min), .z_rise(z_rise),
        .z_with_a(z_with_a), .bad_cnt(bad_cnt), .z_locked(z_locked));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic results();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Bus write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int k;
        @(posedge ref_clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (k = 0; k < 200; k++)
        begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (k == 200) begin num_errors++; results(); end
        rs = bresp;
        bready <= 1'b0;
    endtask
    // Bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int k;
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (k = 0; k < 200; k++)
        begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (k == 200) begin num_errors++; results(); end
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // Move one source n quadrature steps, gap cycles apart
    task automatic step(input int src, input logic fwd, input int n, input int gap);
        repeat (n)
        begin
            qg[src] <= fwd ? qg[src] + 2'h1 : qg[src] - 2'h1;
            wt(gap);
        end
    endtask
    // Config change, settle, clear the host count
    task automatic cfg(input logic [7:0] a, input logic [31:0] v);
        wr(a, v, r);
        wt(150);
        clr <= 1'b1;
        wt(1);
        clr <= 1'b0;
    endtask
    initial
    begin
        wt(10);
        rst_b <= 1'b1;
        wt(5);
        rd(DEPO_OFS_NUM, d, r);  chk(d, {16'h0000, DEPO_NUM_RST});
        rd(DEPO_OFS_DEN, d, r);  chk(d, {16'h0000, DEPO_DEN_RST});
        rd(DEPO_OFS_RES, d, r);  chk(d, {16'h0000, DEPO_RES_RST});
        rd(DEPO_OFS_SEL, d, r);  chk(d, 32'h0000_0000);
        rd(8'h14, d, r);         chk({d[31:2], r}, {30'h0, DEPO_RESP_ERR});
        wr(DEPO_OFS_STAT, 32'h0000_00FF, r);  chk(32'(r), 32'(DEPO_RESP_ERR));
        // Plain ratio, forward then back
        cfg(DEPO_OFS_RES, 32'h0000_2710);
        rd(DEPO_OFS_STAT, d, r); chk(32'(d[0]), 32'h0000_0001);
        step(0, 1'b1, 12, 80); wt(200); chk(pos_cnt, 32'h0000_000C);
        step(0, 1'b0, 12, 80); wt(200); chk(pos_cnt, 32'h0000_0000);
        // Halved ratio
        cfg(DEPO_OFS_DEN, 32'h0000_0002);
        step(0, 1'b1, 16, 80); wt(200); chk(pos_cnt, 32'h0000_0008);
        // Burst faster than the output cap
        cfg(DEPO_OFS_DEN, 32'h0000_0001);
        step(0, 1'b1, 20, 4); wt(1500); chk(pos_cnt, 32'h0000_0014);
        chk(32'(gap_min >= DEPO_STEP_CYC), 32'h0000_0001);
        // B inverted: host sees reverse
        cfg(DEPO_OFS_SEL, 32'h0000_0001);
        step(0, 1'b1, 8, 80); wt(200); chk(pos_cnt, 32'hFFFF_FFF8);
        // Scale source: encoder ignored
        cfg(DEPO_OFS_SEL, 32'h0000_0002);
        step(0, 1'b1, 8, 80); wt(200); chk(pos_cnt, 32'h0000_0000);
        step(1, 1'b1, 8, 80); wt(200); chk(pos_cnt, 32'h0000_0008);
        cfg(DEPO_OFS_SEL, 32'h0000_0000);
        // Aligned index rides on A rising
        za0 = z_with_a;
        enc_z <= 1'b1; wt(10);
        step(0, 1'b1, 1, 100);
        enc_z <= 1'b0;
        step(0, 1'b1, 3, 80); wt(200); chk(z_with_a, za0 + 32'h0000_0001);
        // Narrow index follows the source index
        cfg(DEPO_OFS_RES, 32'h0000_2711);
        rd(DEPO_OFS_STAT, d, r); chk(32'(d[0]), 32'h0000_0000);
        chk(32'(d[2]), 32'h0000_0001);
        za0 = z_with_a;
        enc_z <= 1'b1; wt(10);
        chk({28'h0, zp, zn, zs_oe, zs_o}, 32'h0000_000A);
        enc_z <= 1'b0; wt(10);
        chk({28'h0, zp, zn, zs_oe, zs_o}, 32'h0000_0004);
        chk(z_with_a, za0);
        chk(32'(z_locked), 32'h0000_0001);
        chk(bad_cnt, 32'h0000_0000);
        results();
    end
endmodule
`default_nettype wire
